// [hw/tfmt_formatter.sv]
// Temperature result formatter with APB registers, limits and flags
//
// Functional notes
// - Default span 0..127, plain unsigned whole degrees
// - Default span: below zero reads 00
// - Default span: above 127 reads 7f
// - Config bit 2 selects extended span
// - Span change applies from next conversion
// - Extended span adds offset of 64
// - Extended codes -64..191, clamped outside
// - Stored limits never reformatted on span change
// - Two bytes; high byte one degree per step
// - Low byte carries the fraction
// - Remote fraction fixed at one sixteenth
// - Local fraction selectable half to sixteenth
// - Fraction in upper nibble, truncated, low zero
// - Alarm on high or low limit crossing
// - Separate overheat limits drive second flag
// - Both flags open drain, pull low only
// - Independent local and remote channels
`include "tfmt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tfmt_formatter #(
   parameter int RAW_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire tfmt_pkg::tfmt_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic local_conv_done,
   input wire logic signed [RAW_W-1:0] local_conv_value,
   input wire logic remote_conv_done,
   input wire logic signed [RAW_W-1:0] remote_conv_value,
   input wire logic alarm_pin_i,
   output logic alarm_pin_o,
   output logic alarm_pin_oe,
   input wire logic overheat_flag_out_i,
   output logic overheat_flag_out_o,
   output logic overheat_flag_out_oe,
   output logic irq
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   // Raw values carry four fraction bits and need room for 191 degrees
   generate
      if (RAW_W < 13 || RAW_W > 24) begin : g_bad_width
         $error("tfmt_formatter: RAW_W must lie in 13..24");
      end
   endgenerate

   // ------------------------------------------------------------
   // Constant sanity
   // ------------------------------------------------------------
   // Status bits must fit the status word, or an event is lost
   generate
      if (`TFMT_ST_LOCAL_DONE >= `TFMT_ST_W ||
          `TFMT_ST_REMOTE_DONE >= `TFMT_ST_W ||
          `TFMT_ST_ALARM >= `TFMT_ST_W ||
          `TFMT_ST_OVERHEAT >= `TFMT_ST_W) begin : g_bad_status
         $error("tfmt_formatter: status bit outside status word");
      end
   endgenerate

   // Span tops must fit the high byte; the clamp relies on it
   generate
      if (`TFMT_STD_MAX > 255 || `TFMT_EXT_MAX > 255 ||
          `TFMT_STD_MAX + `TFMT_EXT_OFFSET > `TFMT_EXT_MAX) begin : g_bad_span
         $error("tfmt_formatter: span constants do not fit a byte");
      end
   endgenerate

   // Span select must be one of the stored config bits
   generate
      if (`TFMT_CFG_RANGE_BIT > 7) begin : g_bad_range_bit
         $error("tfmt_formatter: range bit outside config byte");
      end
   endgenerate

   // Fraction fills the upper nibble only, so exactly four bits
   generate
      if (`TFMT_FRAC_BITS != 4) begin : g_bad_frac
         $error("tfmt_formatter: fraction must be four bits");
      end
   endgenerate

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0] config_ff;
   logic [1:0] resolution_ff;
   tfmt_pkg::tfmt_result_t local_res_ff;
   tfmt_pkg::tfmt_result_t remote_res_ff;
   tfmt_pkg::tfmt_result_t nxt_local_res;
   tfmt_pkg::tfmt_result_t nxt_remote_res;
   logic [7:0] loc_hi_lim_ff;
   logic [7:0] loc_lo_lim_ff;
   logic [7:0] rem_hi_lim_ff;
   logic [7:0] rem_lo_lim_ff;
   logic [7:0] loc_ovh_lim_ff;
   logic [7:0] rem_ovh_lim_ff;
   logic [`TFMT_ST_W-1:0] irq_status_ff;
   logic [`TFMT_ST_W-1:0] irq_mask_ff;
   logic [`TFMT_ST_W-1:0] nxt_irq_status;
   logic [`TFMT_ST_W-1:0] st_events;
   logic [31:0] prdata_ff;
   logic alarm_ff;
   logic overheat_ff;
   logic nxt_alarm;
   logic nxt_overheat;
   logic [3:0] local_mask;
   logic setup_phase;
   logic access_phase;
   logic wr_en;
   logic addr_hit;
   logic [31:0] rd_value;

   // ------------------------------------------------------------
   // Formatting function
   // ------------------------------------------------------------
   // Turns a signed sixteenth-degree value into high and low bytes
   function automatic tfmt_pkg::tfmt_result_t fmt_result(
      input logic signed [RAW_W-1:0] raw,
      input logic ext_span,
      input logic [3:0] frac_mask
   );
      tfmt_pkg::tfmt_result_t r;
      int whole;
      int code;
      int top;
      whole = int'(raw >>> `TFMT_FRAC_BITS);
      r.frac = 8'h00;
      code = ext_span ? whole + `TFMT_EXT_OFFSET : whole;
      top = ext_span ? `TFMT_EXT_MAX : `TFMT_STD_MAX;
      if (code < 0) begin
         r.whole = 8'h00;
      end else if (code > top) begin
         r.whole = 8'(top);
      end else begin
         r.whole = 8'(code);
         r.frac = {raw[`TFMT_FRAC_BITS-1:0] & frac_mask, 4'h0};
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Local resolution decode
   // ------------------------------------------------------------
   // local fraction mask select
   always_comb begin
      case (tfmt_pkg::tfmt_res_t'(resolution_ff))
         tfmt_pkg::TFMT_RES_HALF: local_mask = `TFMT_MASK_HALF;
         tfmt_pkg::TFMT_RES_QUARTER: local_mask = `TFMT_MASK_QUARTER;
         tfmt_pkg::TFMT_RES_EIGHTH: local_mask = `TFMT_MASK_EIGHTH;
         tfmt_pkg::TFMT_RES_SIXTEENTH: local_mask = `TFMT_MASK_SIXTEENTH;
         default: local_mask = `TFMT_MASK_SIXTEENTH;
      endcase
   end

   // ------------------------------------------------------------
   // Conversion capture
   // ------------------------------------------------------------
   // Span bit sampled only at conversion end
   always_comb begin
      nxt_local_res = fmt_result(local_conv_value,
         config_ff[`TFMT_CFG_RANGE_BIT], local_mask);
      nxt_remote_res = fmt_result(remote_conv_value,
         config_ff[`TFMT_CFG_RANGE_BIT], `TFMT_MASK_SIXTEENTH);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_res_ff <= '0;
      end else if (local_conv_done) begin
         local_res_ff <= nxt_local_res;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_res_ff <= '0;
      end else if (remote_conv_done) begin
         remote_res_ff <= nxt_remote_res;
      end
   end

   // ------------------------------------------------------------
   // Limit comparison
   // ------------------------------------------------------------
   // Limits compared raw; a span change leaves them stale on purpose
   always_comb begin
      nxt_alarm = (local_res_ff.whole > loc_hi_lim_ff) ||
                  (local_res_ff.whole < loc_lo_lim_ff) ||
                  (remote_res_ff.whole > rem_hi_lim_ff) ||
                  (remote_res_ff.whole < rem_lo_lim_ff);
      nxt_overheat = (local_res_ff.whole > loc_ovh_lim_ff) ||
                     (remote_res_ff.whole > rem_ovh_lim_ff);
   end

   // Flag state registered so the pins never glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_ff <= 1'b0;
         overheat_ff <= 1'b0;
      end else begin
         alarm_ff <= nxt_alarm;
         overheat_ff <= nxt_overheat;
      end
   end

   // ------------------------------------------------------------
   // Open-drain flag pins
   // ------------------------------------------------------------
   // pull low only, wired-OR safe
   assign alarm_pin_o = 1'b0;
   assign alarm_pin_oe = alarm_ff;
   assign overheat_flag_out_o = 1'b0;
   assign overheat_flag_out_oe = overheat_ff;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Zero wait states; read data is staged in the setup cycle
   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign access_phase = apb_req.psel && apb_req.penable;
   assign wr_en = access_phase && apb_req.pwrite && addr_hit;
   assign pready = 1'b1;
   assign pslverr = access_phase && !addr_hit;
   assign prdata = prdata_ff;

   // Address decode and read mux
   always_comb begin
      addr_hit = 1'b1;
      rd_value = 32'h0000_0000;
      case (apb_req.paddr)
         `TFMT_OFF_CONFIG: rd_value = {24'h0, config_ff};
         `TFMT_OFF_RESOLUTION: rd_value = {30'h0, resolution_ff};
         `TFMT_OFF_LOCAL_RES: rd_value = {16'h0, local_res_ff};
         `TFMT_OFF_REMOTE_RES: rd_value = {16'h0, remote_res_ff};
         `TFMT_OFF_LOC_HI_LIM: rd_value = {24'h0, loc_hi_lim_ff};
         `TFMT_OFF_LOC_LO_LIM: rd_value = {24'h0, loc_lo_lim_ff};
         `TFMT_OFF_REM_HI_LIM: rd_value = {24'h0, rem_hi_lim_ff};
         `TFMT_OFF_REM_LO_LIM: rd_value = {24'h0, rem_lo_lim_ff};
         `TFMT_OFF_LOC_OVH_LIM: rd_value = {24'h0, loc_ovh_lim_ff};
         `TFMT_OFF_REM_OVH_LIM: rd_value = {24'h0, rem_ovh_lim_ff};
         `TFMT_OFF_IRQ_STATUS: rd_value = {28'h0, irq_status_ff};
         `TFMT_OFF_IRQ_MASK: rd_value = {28'h0, irq_mask_ff};
         default: addr_hit = 1'b0;
      endcase
   end

   // Read data captured at setup, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_phase && !apb_req.pwrite) begin
         prdata_ff <= rd_value;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // span select written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_ff <= `TFMT_RST_CONFIG;
      end else if (wr_en && apb_req.paddr == `TFMT_OFF_CONFIG) begin
         config_ff <= apb_req.pwdata[7:0];
      end
   end

   // Local resolution select bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resolution_ff <= `TFMT_RST_RESOLUTION;
      end else if (wr_en && apb_req.paddr == `TFMT_OFF_RESOLUTION) begin
         resolution_ff <= apb_req.pwdata[1:0];
      end
   end

   // Alarm limits, stored exactly as written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loc_hi_lim_ff <= `TFMT_RST_HI_LIM;
         loc_lo_lim_ff <= `TFMT_RST_LO_LIM;
         rem_hi_lim_ff <= `TFMT_RST_HI_LIM;
         rem_lo_lim_ff <= `TFMT_RST_LO_LIM;
      end else if (wr_en) begin
         case (apb_req.paddr)
            `TFMT_OFF_LOC_HI_LIM: loc_hi_lim_ff <= apb_req.pwdata[7:0];
            `TFMT_OFF_LOC_LO_LIM: loc_lo_lim_ff <= apb_req.pwdata[7:0];
            `TFMT_OFF_REM_HI_LIM: rem_hi_lim_ff <= apb_req.pwdata[7:0];
            `TFMT_OFF_REM_LO_LIM: rem_lo_lim_ff <= apb_req.pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Overheat limits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loc_ovh_lim_ff <= `TFMT_RST_OVH_LIM;
         rem_ovh_lim_ff <= `TFMT_RST_OVH_LIM;
      end else if (wr_en) begin
         case (apb_req.paddr)
            `TFMT_OFF_LOC_OVH_LIM: loc_ovh_lim_ff <= apb_req.pwdata[7:0];
            `TFMT_OFF_REM_OVH_LIM: rem_ovh_lim_ff <= apb_req.pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   // Events: conversion done, and rising edges of the two flags
   always_comb begin
      st_events = '0;
      st_events[`TFMT_ST_LOCAL_DONE] = local_conv_done;
      st_events[`TFMT_ST_REMOTE_DONE] = remote_conv_done;
      st_events[`TFMT_ST_ALARM] = nxt_alarm && !alarm_ff;
      st_events[`TFMT_ST_OVERHEAT] = nxt_overheat && !overheat_ff;
   end

   // Write one to clear; a same-cycle event wins over the clear
   always_comb begin
      nxt_irq_status = irq_status_ff;
      if (wr_en && apb_req.paddr == `TFMT_OFF_IRQ_STATUS) begin
         nxt_irq_status = irq_status_ff & ~apb_req.pwdata[`TFMT_ST_W-1:0];
      end
      nxt_irq_status = nxt_irq_status | st_events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_ff <= '0;
      end else begin
         irq_status_ff <= nxt_irq_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= `TFMT_RST_IRQ_MASK;
      end else if (wr_en && apb_req.paddr == `TFMT_OFF_IRQ_MASK) begin
         irq_mask_ff <= apb_req.pwdata[`TFMT_ST_W-1:0];
      end
   end

   // Level interrupt while any enabled status bit is set
   assign irq = |(irq_status_ff & irq_mask_ff);

endmodule

`default_nettype wire

// [hw/tfmt_params.svh]
// Offsets, field positions, reset values and constants of the formatter
`ifndef TFMT_PARAMS_SVH
`define TFMT_PARAMS_SVH

// Register byte offsets
`define TFMT_OFF_CONFIG      12'h000
`define TFMT_OFF_RESOLUTION  12'h004
`define TFMT_OFF_LOCAL_RES   12'h008
`define TFMT_OFF_REMOTE_RES  12'h00c
`define TFMT_OFF_LOC_HI_LIM  12'h010
`define TFMT_OFF_LOC_LO_LIM  12'h014
`define TFMT_OFF_REM_HI_LIM  12'h018
`define TFMT_OFF_REM_LO_LIM  12'h01c
`define TFMT_OFF_LOC_OVH_LIM 12'h020
`define TFMT_OFF_REM_OVH_LIM 12'h024
`define TFMT_OFF_IRQ_STATUS  12'h028
`define TFMT_OFF_IRQ_MASK    12'h02c

// Field positions
`define TFMT_CFG_RANGE_BIT   2
`define TFMT_ST_LOCAL_DONE   0
`define TFMT_ST_REMOTE_DONE  1
`define TFMT_ST_ALARM        2
`define TFMT_ST_OVERHEAT     3
`define TFMT_ST_W            4

// Reset values
`define TFMT_RST_CONFIG      8'h00
`define TFMT_RST_RESOLUTION  2'h3
`define TFMT_RST_HI_LIM      8'h55
`define TFMT_RST_LO_LIM      8'h00
`define TFMT_RST_OVH_LIM     8'h55
`define TFMT_RST_IRQ_MASK    4'h0

// Number formats
`define TFMT_FRAC_BITS       4
`define TFMT_EXT_OFFSET      64
`define TFMT_STD_MAX         127
`define TFMT_EXT_MAX         255
`define TFMT_MASK_HALF       4'h8
`define TFMT_MASK_QUARTER    4'hc
`define TFMT_MASK_EIGHTH     4'he
`define TFMT_MASK_SIXTEENTH  4'hf

`endif

// [hw/tfmt_pkg.sv]
// Types shared by the temperature result formatter
package tfmt_pkg;
   // One channel's two-byte result
   typedef struct packed {
      logic [7:0] whole;
      logic [7:0] frac;
   } tfmt_result_t;

   // Local fraction resolution codes
   typedef enum logic [1:0] {
      TFMT_RES_HALF,
      TFMT_RES_QUARTER,
      TFMT_RES_EIGHTH,
      TFMT_RES_SIXTEENTH
   } tfmt_res_t;

   // APB request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tfmt_apb_req_t;
endpackage

// [sim/tfmt_formatter_assertions.sv]
// Port-level checker for the temperature result formatter
`timescale 1ns/1ps
`default_nettype none
module tfmt_formatter_assertions #(
   parameter int RAW_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire tfmt_pkg::tfmt_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic local_conv_done,
   input wire logic remote_conv_done,
   input wire logic alarm_pin_o,
   input wire logic alarm_pin_oe,
   input wire logic overheat_flag_out_o,
   input wire logic overheat_flag_out_oe,
   input wire logic irq
);
   logic [3:0] mask_ff;
   logic acc_wr;
   logic ev;
   // Any cause that may move a flag
   assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign ev = local_conv_done | remote_conv_done | acc_wr;
   // Shadow of the interrupt mask, seen only through bus writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= 4'h0;
      end else if (acc_wr && apb_req.paddr == 12'h02c) begin
         mask_ff <= apb_req.pwdata[3:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_alarm_low_only: assert property (alarm_pin_o == 1'b0)
      else $error("alarm pin driven high");
   a_ovh_low_only: assert property (overheat_flag_out_o == 1'b0)
      else $error("overheat pin driven high");
   a_read_held: assert property (
      !(apb_req.psel && !apb_req.penable) |=> $stable(prdata))
      else $error("read data moved outside a setup cycle");
   a_alarm_has_cause: assert property (
      $changed(alarm_pin_oe) |-> $past(ev) || $past(ev, 2))
      else $error("alarm moved with no conversion or write");
   a_ovh_has_cause: assert property (
      $changed(overheat_flag_out_oe) |-> $past(ev) || $past(ev, 2))
      else $error("overheat moved with no conversion or write");
   a_irq_local_done: assert property (
      local_conv_done && mask_ff[0] |-> ##[1:2] irq)
      else $error("local done did not raise irq");
   a_irq_remote_done: assert property (
      remote_conv_done && mask_ff[1] |-> ##[1:2] irq)
      else $error("remote done did not raise irq");
   a_irq_masked_off: assert property (mask_ff == 4'h0 |-> !irq)
      else $error("irq high with all sources masked");
endmodule
bind tfmt_formatter tfmt_formatter_assertions #(.RAW_W(RAW_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
   .local_conv_done(local_conv_done), .remote_conv_done(remote_conv_done),
   .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
   .overheat_flag_out_o(overheat_flag_out_o),
   .overheat_flag_out_oe(overheat_flag_out_oe), .irq(irq));
`default_nettype wire

// [sim/tfmt_host.sv]
// Behavioural APB host standing in for the system controller
`timescale 1ns/1ps
`default_nettype none
module tfmt_host (
   input wire logic pclk,
   output var tfmt_pkg::tfmt_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial apb_req = '0;
   // Setup cycle, then access held until ready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] wd, output logic [31:0] q, output logic er);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                   pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      // Released bus shows no stale address or data
      apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a,
                   pwdata: ~wd};
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] x;
      logic e;
      xfer(1'b1, a, wd, x, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] x,
         output logic e);
      xfer(1'b0, a, 32'h0, x, e);
   endtask
endmodule
`default_nettype wire

// [sim/tfmt_formatter_bench.sv]
// Self-checking bench for the temperature result formatter
`timescale 1ns/1ps
`default_nettype none
module tfmt_formatter_bench;
   logic pclk, presetn, irq, pready, pslverr, err;
   logic local_conv_done, remote_conv_done;
   logic signed [15:0] local_conv_value, remote_conv_value;
   logic alarm_pin_o, alarm_pin_oe, overheat_flag_out_o, overheat_flag_out_oe;
   logic [31:0] prdata, d;
   tfmt_pkg::tfmt_apb_req_t apb_req;
   wire logic alarm_line, ovh_line;
   int n_fail = 0;
   int num_checks = 0;
   logic [15:0] tv [10] = '{16'h0190, 16'hfff0, 16'h0c80, 16'h07ff,
      16'h0008, 16'hfc00, 16'hfbf0, 16'h0bf8, 16'h0c00, 16'h0000};
   logic [3:0] msk [4] = '{4'h8, 4'hc, 4'he, 4'hf};
   // Open-drain lines with pull-ups
   assign alarm_line = alarm_pin_oe ? alarm_pin_o : 1'b1;
   assign ovh_line = overheat_flag_out_oe ? overheat_flag_out_o : 1'b1;
   tfmt_formatter #(.RAW_W(16)) uut (.pclk(pclk), .presetn(presetn),
      .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .local_conv_done(local_conv_done),
      .local_conv_value(local_conv_value),
      .remote_conv_done(remote_conv_done),
      .remote_conv_value(remote_conv_value), .alarm_pin_i(alarm_line),
      .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
      .overheat_flag_out_i(ovh_line),
      .overheat_flag_out_o(overheat_flag_out_o),
      .overheat_flag_out_oe(overheat_flag_out_oe), .irq(irq));
   tfmt_host host (.pclk(pclk), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // Expected result word: whole byte, then truncated fraction nibble
   function automatic logic [15:0] fmt(input logic [15:0] v,
         input logic ext, input logic [3:0] m);
      int w;
      w = $signed(v[15:4]) + (ext ? 64 : 0);
      if (w < 0) return 16'h0000;
      if (w > (ext ? 255 : 127)) return ext ? 16'hff00 : 16'h7f00;
      return {w[7:0], v[3:0] & m, 4'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // One done pulse; flags settle two edges later
   task automatic conv(input logic rem, input logic [15:0] v);
      @(posedge pclk);
      if (rem) begin
         remote_conv_done <= 1'b1;
         remote_conv_value <= v;
      end else begin
         local_conv_done <= 1'b1;
         local_conv_value <= v;
      end
      @(posedge pclk);
      {local_conv_done, remote_conv_done} <= 2'h0;
      {local_conv_value, remote_conv_value} <= {~v, v};
      repeat (2) @(posedge pclk);
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      final_report();
   end
   //--------------------------------------------------------------
   // Tests
   //--------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {local_conv_done, remote_conv_done} = 2'h0;
      {local_conv_value, remote_conv_value} = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      host.rd(12'h004, d, err); chk("res reset", 32'h3, d);
      host.rd(12'h008, d, err); chk("result reset", 32'h0, d);
      // Every local resolution; remote stays at sixteenths
      for (int r = 0; r < 4; r++) begin
         host.wr(12'h004, r);
         conv(0, 16'h000f); conv(1, 16'h000f);
         host.rd(12'h008, d, err); chk("local frac", fmt(16'h000f, 0, msk[r]), d);
         host.rd(12'h00c, d, err); chk("remote frac", 32'hf0, d);
      end
      // Limits and open-drain flags in the standard span
      conv(0, 16'h0190); conv(1, 16'h0190);
      chk("alarm idle", 32'h1, {31'h0, alarm_line});
      host.wr(12'h010, 32'h19);
      conv(0, 16'h01a0);
      chk("alarm", 32'h0, {31'h0, alarm_line});
      chk("overheat idle", 32'h1, {31'h0, ovh_line});
      conv(0, 16'h05a0);
      chk("overheat", 32'h0, {31'h0, ovh_line});
      // Interrupt raised, seen in status, cleared by write-one
      host.wr(12'h028, 32'hf);
      host.wr(12'h02c, 32'h3);
      @(posedge pclk);
      chk("irq idle", 32'h0, {31'h0, irq});
      conv(0, 16'h0190);
      chk("irq", 32'h1, {31'h0, irq});
      host.rd(12'h028, d, err); chk("done bit", 32'h1, d);
      host.wr(12'h028, 32'hf);
      @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      conv(1, 16'h0190);
      host.rd(12'h028, d, err); chk("remote bit", 32'h2, d);
      host.wr(12'h028, 32'hf);
      host.wr(12'h02c, 32'h0);
      // Both spans, both channels, boundary and clamped values
      for (int e = 0; e < 2; e++) begin
         host.wr(12'h000, {29'h0, e[0], 2'h0});
         if (e == 1) begin
            host.rd(12'h008, d, err); chk("kept", fmt(tv[9], 0, 4'hf), d);
         end
         for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 10; i++) begin
               conv(c[0], tv[i]);
               host.rd(c ? 12'h00c : 12'h008, d, err);
               chk("result", fmt(tv[i], e[0], 4'hf), d);
            end
         end
      end
      // Stored limit unchanged by span change; host rewrites it
      host.rd(12'h010, d, err); chk("limit kept", 32'h19, d);
      host.wr(12'h010, 32'h59);
      host.rd(12'h010, d, err); chk("limit rewritten", 32'h59, d);
      host.rd(12'h030, d, err); chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, d);
      final_report();
   end
endmodule
`default_nettype wire
